/* hdl/sysmgt_decode.sv */
`timescale 1ns/100ps
module sysmgt_decode (
   input  wire logic [11:0]          code,
   output sysmgt_pkg::cmd_kind_t     kind
);

   // ==========================================================
   // classify one command code
   always_comb begin
      kind = sysmgt_pkg::CK_RESERVED;
      unique case (code[11:4])
         sysmgt_pkg::GRP_LEGACY_IN:  kind = sysmgt_pkg::CK_LEGACY_IN;
         sysmgt_pkg::GRP_FLOAT_ERR:  kind = sysmgt_pkg::CK_FLOAT_ERR;
         sysmgt_pkg::GRP_CLK_STOP:   kind = sysmgt_pkg::CK_CLK_STOP;
         sysmgt_pkg::GRP_SHUTDOWN:   kind = sysmgt_pkg::CK_SHUTDOWN;
         sysmgt_pkg::GRP_HALT:       kind = sysmgt_pkg::CK_HALT;
         sysmgt_pkg::GRP_STOP_GRANT: kind = sysmgt_pkg::CK_STOP_GRANT;
         sysmgt_pkg::GRP_VF_CHANGE:  kind = sysmgt_pkg::CK_VF_CHANGE;
         sysmgt_pkg::GRP_WB_INVAL:   kind = sysmgt_pkg::CK_WB_INVAL;
         sysmgt_pkg::GRP_CACHE_INVAL: kind = sysmgt_pkg::CK_CACHE_INVAL;
         sysmgt_pkg::GRP_MGMT_ACK:   kind = sysmgt_pkg::CK_MGMT_ACK;
         sysmgt_pkg::GRP_IRQ:        kind = sysmgt_pkg::CK_IRQ;
         sysmgt_pkg::GRP_THROTTLE:   kind = sysmgt_pkg::CK_THROTTLE;
         sysmgt_pkg::GRP_THERMAL: begin
            if (code[sysmgt_pkg::B_LEVEL]) kind = sysmgt_pkg::CK_THERMAL;
         end
         sysmgt_pkg::GRP_VWIRE_LO: begin
            if (code == sysmgt_pkg::CODE_INT_PENDING) begin
               kind = sysmgt_pkg::CK_INT_PENDING;
            end else if (code != sysmgt_pkg::CODE_ARCH_RESERVED) begin
               kind = sysmgt_pkg::CK_VWIRE;
            end
         end
         sysmgt_pkg::GRP_VWIRE_HI:   kind = sysmgt_pkg::CK_VWIRE;
         default: begin
            if (code[11:7] == sysmgt_pkg::CORE_MGMT_GRP) kind = sysmgt_pkg::CK_CORE_MGMT;
            if (code[11:7] == sysmgt_pkg::CORE_PSTATE) kind = sysmgt_pkg::CK_PSTATE;
         end
      endcase
   end

endmodule

/* hdl/sysmgt_encode.sv */
`timescale 1ns/100ps
module sysmgt_encode (
   input  wire sysmgt_pkg::cmd_kind_t kind,
   input  wire logic [7:0]            arg,
   output logic [11:0]                code,
   output logic                       legal
);

   // ==========================================================
   // build a downstream code, reserved and free bits zero
   always_comb begin
      code  = 12'h000;
      legal = 1'b1;
      unique case (kind)
         sysmgt_pkg::CK_FLOAT_ERR:   code = {sysmgt_pkg::GRP_FLOAT_ERR, 3'h0, arg[0]};
         sysmgt_pkg::CK_MGMT_ACK:    code = {sysmgt_pkg::GRP_MGMT_ACK, 3'h0, arg[0]};
         sysmgt_pkg::CK_SHUTDOWN:    code = {sysmgt_pkg::GRP_SHUTDOWN, 4'h0};
         sysmgt_pkg::CK_VF_CHANGE:   code = {sysmgt_pkg::GRP_VF_CHANGE, 4'h0};
         sysmgt_pkg::CK_WB_INVAL:    code = {sysmgt_pkg::GRP_WB_INVAL, 4'h0};
         sysmgt_pkg::CK_CACHE_INVAL: code = {sysmgt_pkg::GRP_CACHE_INVAL, 4'h0};
         sysmgt_pkg::CK_HALT:        code = {sysmgt_pkg::GRP_HALT, arg[0], 3'h0};
         sysmgt_pkg::CK_STOP_GRANT:  code = {sysmgt_pkg::GRP_STOP_GRANT, arg[2:0], 1'b0};
         sysmgt_pkg::CK_THROTTLE:    code = {sysmgt_pkg::GRP_THROTTLE, 3'h0, arg[0]};
         sysmgt_pkg::CK_THERMAL:     code = {sysmgt_pkg::GRP_THERMAL, 4'h1};
         sysmgt_pkg::CK_INT_PENDING: code = sysmgt_pkg::CODE_INT_PENDING;
         sysmgt_pkg::CK_VWIRE: begin
            code  = {4'h0, arg};
            legal = code >= sysmgt_pkg::CODE_VWIRE_FIRST;
         end
         sysmgt_pkg::CK_CORE_MGMT:   code = {sysmgt_pkg::CORE_MGMT_GRP, arg[6:0]};
         sysmgt_pkg::CK_PSTATE:      code = {sysmgt_pkg::CORE_PSTATE, arg[6:0]};
         default:                    legal = 1'b0;  // upstream-only or reserved
      endcase
   end

endmodule

/* hdl/sysmgt_host_ctrl.sv */
`timescale 1ns/100ps
module sysmgt_host_ctrl #(
   parameter int IRQ_CNT_W = 4
) (
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clk_en,
   input  wire logic                  rx_valid,
   input  wire logic [11:0]           rx_code,
   output logic                       tx_valid,
   output logic [11:0]                tx_code,
   input  wire logic                  tx_ready,
   input  wire logic                  req_valid,
   input  wire sysmgt_pkg::cmd_kind_t req_kind,
   input  wire logic [7:0]            req_arg,
   output logic                       req_ready,
   output logic                       req_reject,
   output logic                       numeric_error_ignore_wire,
   output logic                       address_bit20_mask_wire,
   output logic                       clock_stop_request_wire,
   output logic [2:0]                 power_action_code,
   output logic [3:0]                 legacy_irq_line,
   output logic                       irq_count_error,
   output logic                       vwire_valid,
   output logic [7:0]                 vwire_code,
   output logic                       core_mgmt_valid,
   output logic [6:0]                 core_mgmt_payload,
   output logic                       bad_code
);

   // ==========================================================
   // state
   typedef struct packed {
      logic                                tx_valid;
      logic [11:0]                         tx_code;
      logic                                req_ready;
      logic                                req_reject;
      logic                                numerr;
      logic                                a20;
      logic                                stop_req;
      logic [2:0]                          pac;
      logic                                grant_pend;
      logic [2:0]                          grant_pac;
      logic [3:0][IRQ_CNT_W-1:0]           irq_cnt;
      logic [3:0]                          irq_line;
      logic                                irq_err;
      logic                                vwire_valid;
      logic [7:0]                          vwire_code;
      logic                                core_mgmt_valid;
      logic [6:0]                          core_mgmt;
      logic                                bad_code;
   } state_t;

   state_t                st_q;
   state_t                st_d;
   sysmgt_pkg::cmd_kind_t rx_kind;
   logic [11:0]           req_code;
   logic                  req_legal;
   logic                  tx_free;
   logic                  accept;
   logic [1:0]            irq_sel;

   sysmgt_decode u_decode (
      .code (rx_code),
      .kind (rx_kind)
   );

   sysmgt_encode u_encode (
      .kind  (req_kind),
      .arg   (req_arg),
      .code  (req_code),
      .legal (req_legal)
   );

   assign tx_free = !st_q.tx_valid || tx_ready;
   assign accept  = req_valid && st_q.req_ready;
   assign irq_sel = rx_code[sysmgt_pkg::IRQ_SEL_LSB +: 2];

   // ==========================================================
   // next state
   always_comb begin
      st_d             = st_q;
      st_d.req_reject  = 1'b0;
      st_d.irq_err     = 1'b0;
      st_d.vwire_valid = 1'b0;
      st_d.core_mgmt_valid = 1'b0;
      st_d.bad_code    = 1'b0;

      // downstream slot: grant first, then a user request
      if (tx_free) begin
         st_d.tx_valid = 1'b0;
         if (st_q.grant_pend) begin
            st_d.tx_valid   = 1'b1;
            st_d.tx_code    = {sysmgt_pkg::GRP_STOP_GRANT, st_q.grant_pac, 1'b0};
            st_d.grant_pend = 1'b0;
         end else if (accept && req_legal) begin
            st_d.tx_valid = 1'b1;
            st_d.tx_code  = req_code;
         end else if (accept) begin
            st_d.req_reject = 1'b1;
         end
      end

      // upstream messages; a new stop request after the grant wins
      if (rx_valid) begin
         unique case (rx_kind)
            sysmgt_pkg::CK_LEGACY_IN: begin
               st_d.numerr = rx_code[sysmgt_pkg::B_NUMERR];
               st_d.a20    = rx_code[sysmgt_pkg::B_A20];
            end
            sysmgt_pkg::CK_CLK_STOP: begin
               st_d.stop_req   = rx_code[sysmgt_pkg::B_STOP_REQ];
               st_d.pac        = rx_code[sysmgt_pkg::PAC_LSB +: sysmgt_pkg::PAC_W];
               st_d.grant_pend = rx_code[sysmgt_pkg::B_STOP_REQ];
               st_d.grant_pac  = rx_code[sysmgt_pkg::PAC_LSB +: sysmgt_pkg::PAC_W];
            end
            sysmgt_pkg::CK_IRQ: begin
               if (rx_code[sysmgt_pkg::B_IRQ_ASSERT]) begin
                  if (&st_q.irq_cnt[irq_sel]) st_d.irq_err = 1'b1;
                  else st_d.irq_cnt[irq_sel] = st_q.irq_cnt[irq_sel] + 1'b1;
               end else begin
                  if (st_q.irq_cnt[irq_sel] == '0) st_d.irq_err = 1'b1;
                  else st_d.irq_cnt[irq_sel] = st_q.irq_cnt[irq_sel] - 1'b1;
               end
            end
            sysmgt_pkg::CK_VWIRE: begin
               st_d.vwire_valid = 1'b1;
               st_d.vwire_code  = rx_code[7:0];
            end
            sysmgt_pkg::CK_CORE_MGMT: begin
               st_d.core_mgmt_valid = 1'b1;
               st_d.core_mgmt       = rx_code[sysmgt_pkg::CORE_PAY_W-1:0];
            end
            // reserved, host-origin and upstream core state codes
            default: st_d.bad_code = 1'b1;
         endcase
      end

      for (int i = 0; i < sysmgt_pkg::IRQ_LINES; i++) begin
         st_d.irq_line[i] = st_d.irq_cnt[i] != '0;
      end
      st_d.req_ready = !st_d.tx_valid && !st_d.grant_pend;
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q        <= '0;
         st_q.numerr <= sysmgt_pkg::RST_WIRE;
         st_q.a20    <= sysmgt_pkg::RST_WIRE;
         st_q.stop_req <= sysmgt_pkg::RST_WIRE;
         st_q.pac    <= sysmgt_pkg::RST_PAC;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   assign tx_valid                  = st_q.tx_valid;
   assign tx_code                   = st_q.tx_code;
   assign req_ready                 = st_q.req_ready;
   assign req_reject                = st_q.req_reject;
   assign numeric_error_ignore_wire = st_q.numerr;
   assign address_bit20_mask_wire   = st_q.a20;
   assign clock_stop_request_wire   = st_q.stop_req;
   assign power_action_code         = st_q.pac;
   assign legacy_irq_line           = st_q.irq_line;
   assign irq_count_error           = st_q.irq_err;
   assign vwire_valid               = st_q.vwire_valid;
   assign vwire_code                = st_q.vwire_code;
   assign core_mgmt_valid           = st_q.core_mgmt_valid;
   assign core_mgmt_payload         = st_q.core_mgmt;
   assign bad_code                  = st_q.bad_code;

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_stop_req;
      clk_en && rx_valid && rx_kind == sysmgt_pkg::CK_CLK_STOP && rx_code[0];
   endsequence

   sequence s_grant_due;
      clk_en && st_q.grant_pend && tx_free;
   endsequence

   a_grant_pending: assert property (s_stop_req |=> st_q.grant_pend
         && st_q.grant_pac == $past(rx_code[3:1]))
      else $error("stop request did not arm a grant");

   a_grant_sent: assert property (s_grant_due |=> tx_valid
         && tx_code == {sysmgt_pkg::GRP_STOP_GRANT, $past(st_q.grant_pac), 1'b0})
      else $error("grant not sent with its action code");

   a_tx_hold: assert property (clk_en && tx_valid && !tx_ready |=> tx_valid && $stable(tx_code))
      else $error("downstream code dropped while stalled");

   a_no_reserved: assert property (tx_valid |-> tx_code[11:4] != sysmgt_pkg::GRP_RESERVED)
      else $error("reserved group sent downstream");

   a_legacy_update: assert property (clk_en && rx_valid && rx_kind == sysmgt_pkg::CK_LEGACY_IN
         |=> numeric_error_ignore_wire == $past(rx_code[0])
         && address_bit20_mask_wire == $past(rx_code[1]))
      else $error("legacy wires not updated");

   a_irq_first: assert property (clk_en && rx_valid && rx_kind == sysmgt_pkg::CK_IRQ && rx_code[1]
         && st_q.irq_cnt[irq_sel] == '0 |=> legacy_irq_line[$past(irq_sel)])
      else $error("irq line not raised on first assert");

   a_bad_flag: assert property (clk_en && rx_valid && (rx_kind == sysmgt_pkg::CK_RESERVED
         || rx_kind == sysmgt_pkg::CK_PSTATE) |=> bad_code ##1 (!bad_code || $past(rx_valid)))
      else $error("reserved or upstream state code not flagged");

   a_thermal_bit: assert property (tx_valid && tx_code[11:4] == sysmgt_pkg::GRP_THERMAL
         |-> tx_code[3:0] == 4'h1)
      else $error("thermal notice without bit 0 set");

   a_halt_state: assert property (clk_en && accept && tx_free && !st_q.grant_pend
         && req_kind == sysmgt_pkg::CK_HALT |=> tx_code == {sysmgt_pkg::GRP_HALT, $past(req_arg[0]), 3'h0})
      else $error("halt code mis-encoded");

   a_vwire_pulse: assert property (clk_en && rx_valid && rx_kind == sysmgt_pkg::CK_VWIRE
         |=> vwire_valid && vwire_code == $past(rx_code[7:0]))
      else $error("vendor wire not reported");

   a_core_mgmt_pass: assert property (clk_en && rx_valid && rx_kind == sysmgt_pkg::CK_CORE_MGMT
         |=> core_mgmt_valid && core_mgmt_payload == $past(rx_code[6:0]))
      else $error("core management payload not passed");

   a_req_refused: assert property (clk_en && accept && tx_free && !st_q.grant_pend && !req_legal
         |=> req_reject && !tx_valid)
      else $error("illegal request not refused");

   a_irq_underflow: assert property (clk_en && rx_valid && rx_kind == sysmgt_pkg::CK_IRQ && !rx_code[1]
         && st_q.irq_cnt[irq_sel] == '0 |=> irq_count_error)
      else $error("irq underflow not flagged");

endmodule

/* hdl/sysmgt_pkg.sv */
package sysmgt_pkg;

   // ==========================================================
   // command field
   localparam int          CODE_W = 12;
   localparam int          ARG_W  = 8;

   // ==========================================================
   // group codes, command bits 11:4
   localparam logic [7:0]  GRP_RESERVED   = 8'h00;
   localparam logic [7:0]  GRP_LEGACY_IN  = 8'h01;
   localparam logic [7:0]  GRP_FLOAT_ERR  = 8'h02;
   localparam logic [7:0]  GRP_CLK_STOP   = 8'h03;
   localparam logic [7:0]  GRP_SHUTDOWN   = 8'h04;
   localparam logic [7:0]  GRP_HALT       = 8'h05;
   localparam logic [7:0]  GRP_STOP_GRANT = 8'h06;
   localparam logic [7:0]  GRP_VF_CHANGE  = 8'h07;
   localparam logic [7:0]  GRP_WB_INVAL   = 8'h08;
   localparam logic [7:0]  GRP_CACHE_INVAL = 8'h09;
   localparam logic [7:0]  GRP_MGMT_ACK   = 8'h0A;
   localparam logic [7:0]  GRP_IRQ        = 8'h0B;
   localparam logic [7:0]  GRP_THROTTLE   = 8'h0C;
   localparam logic [7:0]  GRP_THERMAL    = 8'h0D;
   localparam logic [7:0]  GRP_VWIRE_LO   = 8'h0E;
   localparam logic [7:0]  GRP_VWIRE_HI   = 8'h0F;

   // core groups, command bits 11:7
   localparam logic [4:0]  CORE_MGMT_GRP  = 5'h02;
   localparam logic [4:0]  CORE_PSTATE    = 5'h03;

   localparam logic [11:0] CODE_INT_PENDING   = 12'h0E0;
   localparam logic [11:0] CODE_ARCH_RESERVED = 12'h0E1;
   localparam logic [11:0] CODE_VWIRE_FIRST   = 12'h0E2;

   // ==========================================================
   // field positions
   localparam int          B_NUMERR      = 0;
   localparam int          B_A20         = 1;
   localparam int          B_STOP_REQ    = 0;
   localparam int          B_LEVEL       = 0;
   localparam int          B_HALT_EXIT   = 3;
   localparam int          B_IRQ_ASSERT  = 1;
   localparam int          IRQ_SEL_LSB   = 2;
   localparam int          IRQ_LINES     = 4;
   localparam int          PAC_LSB       = 1;
   localparam int          PAC_W         = 3;
   localparam int          CORE_PAY_W    = 7;

   // ==========================================================
   // reset values
   localparam logic        RST_WIRE      = 1'b0;
   localparam logic [2:0]  RST_PAC       = 3'h0;

   typedef enum logic [4:0] {
      CK_LEGACY_IN, CK_FLOAT_ERR, CK_CLK_STOP, CK_SHUTDOWN, CK_HALT,
      CK_STOP_GRANT, CK_VF_CHANGE, CK_WB_INVAL, CK_CACHE_INVAL, CK_MGMT_ACK,
      CK_IRQ, CK_THROTTLE, CK_THERMAL, CK_INT_PENDING, CK_VWIRE,
      CK_CORE_MGMT, CK_PSTATE, CK_RESERVED
   } cmd_kind_t;

endpackage

/* testbench/chipset_model.sv */
`timescale 1ns/100ps
// ==========================================================
// chipset side: sends upstream messages, sinks downstream ones
module chipset_model #(
   parameter int CORE_COUNT   = 4,
   parameter int PSTATE_COUNT = 8
) (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        slow,
   input  wire logic        tx_valid,
   input  wire logic [11:0] tx_code,
   output logic             tx_ready,
   output logic             rx_valid,
   output logic [11:0]      rx_code
);
   // per-core tracking limits, fixed here instead of programmed
   int          core_limit   = CORE_COUNT;
   int          pstate_limit = PSTATE_COUNT;
   logic [11:0] got[$];
   logic [1:0]  pace;

   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_code  = 12'hA5A;
      pace     = 2'h0;
   end

   // ==========================================================
   // downstream sink; slow mode takes one message in four cycles
   always @(posedge ref_clk) begin
      if (!sys_rst && tx_valid && tx_ready) begin
         got.push_back(tx_code);
      end
      pace = pace + 2'h1;
      #1;
      tx_ready = !sys_rst && (!slow || pace == 2'h0);
   end

   // ==========================================================
   // one upstream message; code lines show inverse when idle
   task automatic send(input logic [11:0] c);
      @(posedge ref_clk);
      #1;
      rx_valid = 1'b1;
      rx_code  = c;
      @(posedge ref_clk);
      #1;
      rx_valid = 1'b0;
      rx_code  = ~c;
   endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
   logic                  ref_clk, sys_rst, clk_en, rx_valid, tx_valid, tx_ready, slow;
   logic                  req_valid, req_ready, req_reject, irq_count_error, bad_code;
   logic                  numeric_error_ignore_wire, address_bit20_mask_wire, clock_stop_request_wire;
   logic                  vwire_valid, core_mgmt_valid;
   logic [11:0]           rx_code, tx_code;
   logic [7:0]            req_arg, vwire_code;
   logic [6:0]            core_mgmt_payload;
   logic [3:0]            legacy_irq_line;
   logic [2:0]            power_action_code;
   sysmgt_pkg::cmd_kind_t req_kind;
   int                    num_errors, check_count;

   sysmgt_host_ctrl #(.IRQ_CNT_W(4)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .rx_valid(rx_valid), .rx_code(rx_code),
      .tx_valid(tx_valid), .tx_code(tx_code), .tx_ready(tx_ready), .req_valid(req_valid),
      .req_kind(req_kind), .req_arg(req_arg), .req_ready(req_ready), .req_reject(req_reject),
      .numeric_error_ignore_wire(numeric_error_ignore_wire), .address_bit20_mask_wire(address_bit20_mask_wire),
      .clock_stop_request_wire(clock_stop_request_wire), .power_action_code(power_action_code),
      .legacy_irq_line(legacy_irq_line), .irq_count_error(irq_count_error), .vwire_valid(vwire_valid),
      .vwire_code(vwire_code), .core_mgmt_valid(core_mgmt_valid), .core_mgmt_payload(core_mgmt_payload),
      .bad_code(bad_code));

   chipset_model chip (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow), .tx_valid(tx_valid), .tx_code(tx_code),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_code(rx_code));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // shared helpers
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask

   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wait_tx(input logic [11:0] exp);
      int n;
      n = 0;
      while (chip.got.size() == 0 && n < 60) begin
         tick();
         n++;
      end
      if (n == 60) begin
         num_errors++;
         close_out();
      end
      check("tx_code", chip.got.pop_front(), exp);
   endtask

   task automatic request(input sysmgt_pkg::cmd_kind_t k, input logic [7:0] a, input logic rej,
                          input logic [11:0] exp);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 60) begin
         tick();
         n++;
      end
      if (n == 60) begin
         num_errors++;
         close_out();
      end
      req_valid = 1'b1;
      req_kind  = k;
      req_arg   = a;
      tick();
      req_valid = 1'b0;
      check("req_reject", {11'h000, req_reject}, {11'h000, rej});
      if (!rej) begin
         wait_tx(exp);
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic test_legacy();
      chip.send(12'h013);
      check("ignore", {11'h000, numeric_error_ignore_wire}, 12'h001);
      check("a20", {11'h000, address_bit20_mask_wire}, 12'h001);
      chip.send(12'h012);
      check("ignore", {11'h000, numeric_error_ignore_wire}, 12'h000);
      clk_en = 1'b0;
      chip.send(12'h010);
      clk_en = 1'b1;
      check("a20", {11'h000, address_bit20_mask_wire}, 12'h001);
      chip.send(12'h010);
      check("a20", {11'h000, address_bit20_mask_wire}, 12'h000);
   endtask

   task automatic test_stop();
      slow = 1'b1;
      chip.send(12'h03B);
      check("stop", {11'h000, clock_stop_request_wire}, 12'h001);
      check("action", {9'h000, power_action_code}, 12'h005);
      wait_tx(12'h06A);
      slow = 1'b0;
      chip.send(12'h030);
      check("stop", {11'h000, clock_stop_request_wire}, 12'h000);
   endtask

   task automatic test_irq();
      chip.send(12'h0B6);
      check("irq", {8'h00, legacy_irq_line}, 12'h002);
      chip.send(12'h0BE);
      check("irq", {8'h00, legacy_irq_line}, 12'h00A);
      chip.send(12'h0B4);
      check("irq", {8'h00, legacy_irq_line}, 12'h008);
      chip.send(12'h0B4);
      check("irq_err", {11'h000, irq_count_error}, 12'h001);
      check("irq", {8'h00, legacy_irq_line}, 12'h008);
      chip.send(12'h0BC);
      check("irq", {8'h00, legacy_irq_line}, 12'h000);
   endtask

   task automatic test_rx_misc();
      logic [11:0] bad[5] = '{12'h005, 12'h0E1, 12'h0D0, 12'h185, 12'h040};
      chip.send(12'h0E5);
      check("vwire_valid", {11'h000, vwire_valid}, 12'h001);
      check("vwire_code", {4'h0, vwire_code}, 12'h0E5);
      chip.send(12'h123);
      check("core_mgmt_valid", {11'h000, core_mgmt_valid}, 12'h001);
      check("core_mgmt", {5'h00, core_mgmt_payload}, 12'h023);
      foreach (bad[i]) begin
         chip.send(bad[i]);
         check("bad_code", {11'h000, bad_code}, 12'h001);
      end
   endtask

   task automatic test_req();
      sysmgt_pkg::cmd_kind_t ks[19] = '{sysmgt_pkg::CK_FLOAT_ERR, sysmgt_pkg::CK_MGMT_ACK,
         sysmgt_pkg::CK_THROTTLE, sysmgt_pkg::CK_THROTTLE, sysmgt_pkg::CK_SHUTDOWN, sysmgt_pkg::CK_HALT,
         sysmgt_pkg::CK_HALT, sysmgt_pkg::CK_STOP_GRANT, sysmgt_pkg::CK_VF_CHANGE, sysmgt_pkg::CK_WB_INVAL,
         sysmgt_pkg::CK_CACHE_INVAL, sysmgt_pkg::CK_THERMAL, sysmgt_pkg::CK_INT_PENDING,
         sysmgt_pkg::CK_VWIRE, sysmgt_pkg::CK_CORE_MGMT, sysmgt_pkg::CK_PSTATE,
         sysmgt_pkg::CK_VWIRE, sysmgt_pkg::CK_LEGACY_IN, sysmgt_pkg::CK_RESERVED};
      logic [7:0]  args[19] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'hFF, 8'h01, 8'h00, 8'h07, 8'h00, 8'h00,
         8'h00, 8'h00, 8'h00, 8'hFF, 8'h55, 8'h7A, 8'hE1, 8'h03, 8'h00};
      logic [11:0] exps[19] = '{12'h021, 12'h0A1, 12'h0C0, 12'h0C1, 12'h040, 12'h058, 12'h050, 12'h06E,
         12'h070, 12'h080, 12'h090, 12'h0D1, 12'h0E0, 12'h0FF, 12'h155, 12'h1FA, 12'h000, 12'h000, 12'h000};
      foreach (ks[i]) begin
         slow = i[0];
         request(ks[i], args[i], i >= 16, exps[i]);
      end
      slow = 1'b0;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      num_errors  = 0;
      check_count = 0;
      sys_rst     = 1'b1;
      clk_en      = 1'b1;
      slow        = 1'b0;
      req_valid   = 1'b0;
      req_kind    = sysmgt_pkg::CK_HALT;
      req_arg     = 8'h00;
      repeat (5) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      check("tx_valid", {11'h000, tx_valid}, 12'h000);
      check("req_ready", {11'h000, req_ready}, 12'h000);
      tick();
      check("req_ready", {11'h000, req_ready}, 12'h001);
      test_legacy();
      test_stop();
      test_irq();
      test_rx_misc();
      test_req();
      close_out();
   end
endmodule
